// File: core/stcs_pkg.sv
/*
 * stcs_pkg: constants for the transmit channel-status register bank.
 * Assumes a decoded register port (7-bit address, 16-bit data) behind the
 * device's control interface, and an encoder that strobes once per frame.
 */
package stcs_pkg;
	// register offsets
	localparam logic [6:0] ADDR_LEFT_HIGH = 7'h51;
	localparam logic [6:0] ADDR_LEFT_MID = 7'h52;
	localparam logic [6:0] ADDR_LEFT_LOW = 7'h53;
	localparam logic [6:0] ADDR_RIGHT_HIGH = 7'h54;
	localparam logic [6:0] ADDR_RIGHT_MID = 7'h55;
	localparam logic [6:0] ADDR_RIGHT_LOW = 7'h56;
	// reset values
	localparam logic [15:0] RST_HIGH = 16'h0000;
	localparam logic [15:0] RST_MID = 16'h0000;
	localparam logic [7:0] RST_LOW = 8'h00;
	// field positions in the 40-bit status word
	localparam int STATUS_BITS = 40;
	localparam int POS_WLEN_HI = 35;
	localparam int POS_WLEN_LO = 33;
	localparam int POS_MAX24 = 32;
	localparam int POS_CLKACC_HI = 29;
	localparam int POS_CLKACC_LO = 28;
	localparam int POS_RATE_HI = 27;
	localparam int POS_RATE_LO = 24;
	localparam int POS_CHAN_HI = 23;
	localparam int POS_CHAN_LO = 20;
	localparam int POS_SRC_HI = 19;
	localparam int POS_SRC_LO = 16;
	localparam int POS_CAT_HI = 15;
	localparam int POS_CAT_LO = 8;
	localparam int POS_NONPCM = 1;
	// sample frequency codes
	localparam logic [3:0] RATE_44K1 = 4'h0;
	localparam logic [3:0] RATE_48K = 4'h1;
	localparam logic [3:0] RATE_32K = 4'h2;
	// clock accuracy reserved code
	localparam logic [1:0] CLKACC_RSVD = 2'h3;
	// status block framing
	localparam logic [7:0] LAST_FRAME = 8'hBF;
	localparam logic [7:0] STATUS_BITS_8 = 8'h28;
endpackage

// File: core/stcs_regs.sv
/*
 * stcs_regs: left/right transmit channel-status registers, field decode
 * and per-frame serialisation toward the output encoder.
 * Assumes one frame_tick_in pulse per frame, block_start_in high with the
 * tick of the first frame of a block, and copy control from elsewhere.
 */
// Functional notes
// - 40-bit word in three registers per channel, 0x51-0x56.
// - middle register holds bits 23..8.
// - bit 32 selects 20 or 24 maximum.
// - bits 35..33 word length; 39..36 reserved.
// - bits 29..28 clock accuracy; 31..30 reserved.
// - bits 27..24 sample frequency code.
// - bits 23..20 channel number code.
// - bits 19..16 source number.
// - bits 15..8 category, sent unchanged.
// - copy control sends left status on right.
// - bit 1 clear means linear PCM.
`timescale 1ns/1ps
module stcs_regs
	import stcs_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	output logic reg_rvalid_out,
	input wire logic copy_left_to_right_in,
	input wire logic frame_tick_in,
	input wire logic block_start_in,
	output logic left_status_bit_out,
	output logic right_status_bit_out,
	output logic [7:0] bit_index_out,
	output logic [4:0] left_word_len_out,
	output logic left_max24_out,
	output logic [1:0] left_clk_acc_out,
	output logic left_rate_known_out,
	output logic [3:0] left_chan_num_out,
	output logic [3:0] left_source_out,
	output logic [7:0] left_category_out,
	output logic left_linear_pcm_out,
	output logic right_linear_pcm_out
);
	logic [15:0] left_high_ff;
	logic [15:0] left_mid_ff;
	logic [7:0] left_low_ff;
	logic [15:0] right_high_ff;
	logic [15:0] right_mid_ff;
	logic [7:0] right_low_ff;
	logic [STATUS_BITS-1:0] left_word;
	logic [STATUS_BITS-1:0] right_own_word;
	logic [STATUS_BITS-1:0] right_word;
	logic [7:0] nxt_index;

	// word length in bits from code and maximum; zero when not given
	function automatic logic [4:0] stcs_wlen(input logic max24, input logic [2:0] code);
		logic [4:0] len;
		len = 5'h00;
		case (code)
			3'h1: len = max24 ? 5'h14 : 5'h10;
			3'h2: len = max24 ? 5'h16 : 5'h12;
			3'h4: len = max24 ? 5'h17 : 5'h13;
			3'h5: len = max24 ? 5'h18 : 5'h14;
			3'h6: len = max24 ? 5'h15 : 5'h11;
			default: len = 5'h00; // not indicated or reserved
		endcase
		return len;
	endfunction

	// assemble the status words; low register upper byte not stored
	assign left_word = {left_high_ff, left_mid_ff, left_low_ff};
	assign right_own_word = {right_high_ff, right_mid_ff, right_low_ff};
	assign right_word = copy_left_to_right_in ? left_word : right_own_word;

	// left register writes
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			left_high_ff <= RST_HIGH;
			left_mid_ff <= RST_MID;
			left_low_ff <= RST_LOW;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_LEFT_HIGH: left_high_ff <= reg_wdata_in;
				ADDR_LEFT_MID: left_mid_ff <= reg_wdata_in;
				ADDR_LEFT_LOW: left_low_ff <= reg_wdata_in[7:0];
				default: ;
			endcase
		end
	end

	// right register writes
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			right_high_ff <= RST_HIGH;
			right_mid_ff <= RST_MID;
			right_low_ff <= RST_LOW;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_RIGHT_HIGH: right_high_ff <= reg_wdata_in;
				ADDR_RIGHT_MID: right_mid_ff <= reg_wdata_in;
				ADDR_RIGHT_LOW: right_low_ff <= reg_wdata_in[7:0];
				default: ;
			endcase
		end
	end

	// register reads, one cycle latency, unmapped reads as zero
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				case (reg_addr_in)
					ADDR_LEFT_HIGH: reg_rdata_out <= left_high_ff;
					ADDR_LEFT_MID: reg_rdata_out <= left_mid_ff;
					ADDR_LEFT_LOW: reg_rdata_out <= {8'h00, left_low_ff};
					ADDR_RIGHT_HIGH: reg_rdata_out <= right_high_ff;
					ADDR_RIGHT_MID: reg_rdata_out <= right_mid_ff;
					ADDR_RIGHT_LOW: reg_rdata_out <= {8'h00, right_low_ff};
					default: reg_rdata_out <= 16'h0000;
				endcase
			end
		end
	end

	// next frame position within the status block
	always_comb begin
		nxt_index = bit_index_out;
		if (block_start_in || bit_index_out == LAST_FRAME) begin
			nxt_index = 8'h00;
		end else begin
			nxt_index = bit_index_out + 8'h01;
		end
	end

	// serialise one status bit per frame on each channel
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_index_out <= LAST_FRAME;
			left_status_bit_out <= 1'b0;
			right_status_bit_out <= 1'b0;
		end else if (frame_tick_in) begin
			bit_index_out <= nxt_index;
			if (nxt_index < STATUS_BITS_8) begin
				left_status_bit_out <= left_word[nxt_index[5:0]];
				right_status_bit_out <= right_word[nxt_index[5:0]];
			end else begin
				left_status_bit_out <= 1'b0;
				right_status_bit_out <= 1'b0;
			end
		end
	end

	// decoded view of the transmitted left fields, plus the right linear pcm flag
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			left_word_len_out <= 5'h00;
			left_max24_out <= 1'b0;
			left_clk_acc_out <= 2'h0;
			left_rate_known_out <= 1'b1;
			left_chan_num_out <= 4'h0;
			left_source_out <= 4'h0;
			left_category_out <= 8'h00;
			left_linear_pcm_out <= 1'b1;
			right_linear_pcm_out <= 1'b1;
		end else begin
			left_word_len_out <= stcs_wlen(left_word[POS_MAX24],
				left_word[POS_WLEN_HI:POS_WLEN_LO]);
			left_max24_out <= left_word[POS_MAX24];
			left_clk_acc_out <= left_word[POS_CLKACC_HI:POS_CLKACC_LO];
			left_rate_known_out <= (left_word[POS_RATE_HI:POS_RATE_LO] == RATE_44K1)
				|| (left_word[POS_RATE_HI:POS_RATE_LO] == RATE_48K)
				|| (left_word[POS_RATE_HI:POS_RATE_LO] == RATE_32K);
			left_chan_num_out <= left_word[POS_CHAN_HI:POS_CHAN_LO];
			left_source_out <= left_word[POS_SRC_HI:POS_SRC_LO];
			left_category_out <= left_word[POS_CAT_HI:POS_CAT_LO];
			left_linear_pcm_out <= !left_word[POS_NONPCM];
			right_linear_pcm_out <= !right_word[POS_NONPCM];
		end
	end

	// read-back of left high register matches stored value
	rd_high_map_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == ADDR_LEFT_HIGH && !reg_wr_in
		|=> reg_rvalid_out && reg_rdata_out == $past(left_high_ff))
		else $error("left high read-back wrong");

	// low register upper byte reads as zero
	low_rsvd_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_rd_in && (reg_addr_in == ADDR_LEFT_LOW || reg_addr_in == ADDR_RIGHT_LOW)
		|=> reg_rdata_out[15:8] == 8'h00)
		else $error("low register upper byte not zero");

	// middle register write then read returns the data
	mid_wr_rd_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == ADDR_RIGHT_MID ##1
		(reg_rd_in && !reg_wr_in && reg_addr_in == ADDR_RIGHT_MID)
		|=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("right mid write not read back");

	// max length flag follows bit 32
	max24_flag_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == ADDR_LEFT_HIGH ##1 !reg_wr_in
		|=> left_max24_out == $past(reg_wdata_in[8], 2))
		else $error("max length flag wrong");

	// word length code 101 gives 20 or 24 bits
	wlen_decode_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		left_word[35:33] == 3'h5
		|=> left_word_len_out == ($past(left_word[32]) ? 5'h18 : 5'h14))
		else $error("word length decode wrong");

	// clock accuracy field passes through
	clk_acc_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		##1 left_clk_acc_out == $past(left_high_ff[5:4]))
		else $error("clock accuracy field wrong");

	// reserved sample frequency code flagged unknown
	rate_rsvd_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		left_high_ff[3:0] > 4'h2 |=> !left_rate_known_out)
		else $error("reserved rate not flagged");

	// copy mode makes right bit equal left bit
	copy_mode_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && copy_left_to_right_in
		|=> right_status_bit_out == left_status_bit_out)
		else $error("copy mode bits differ");

	// linear pcm flag tracks bit 1
	pcm_flag_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		left_low_ff[1] ##1 left_low_ff[1] |-> !left_linear_pcm_out)
		else $error("linear pcm flag wrong");

	// bits past 39 sent as zero
	tail_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		bit_index_out >= STATUS_BITS_8 |-> !left_status_bit_out && !right_status_bit_out)
		else $error("status bit above 39 not zero");

	// block start restarts at bit zero
	block_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && block_start_in
		|=> bit_index_out == 8'h00 && left_status_bit_out == $past(left_word[0]))
		else $error("block start not at bit zero");

	// right high read-back matches stored value
	rd_right_map_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == ADDR_RIGHT_HIGH
		|=> reg_rvalid_out && reg_rdata_out == $past(right_high_ff))
		else $error("right high read-back wrong");

	// low register read returns the stored byte
	rd_low_map_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == ADDR_LEFT_LOW
		|=> reg_rdata_out[7:0] == $past(left_low_ff))
		else $error("left low read-back wrong");

	// left middle read returns bits 23..8
	rd_mid_map_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == ADDR_LEFT_MID
		|=> reg_rdata_out == $past(left_mid_ff))
		else $error("left mid read-back wrong");

	// writes elsewhere leave the left high register alone
	high_wr_only_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in != ADDR_LEFT_HIGH |=> $stable(left_high_ff))
		else $error("left high changed by another write");

	// channel number field passes through
	chan_field_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		##1 left_chan_num_out == $past(left_mid_ff[15:12]))
		else $error("channel number field wrong");

	// source number field passes through
	src_field_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		##1 left_source_out == $past(left_mid_ff[11:8]))
		else $error("source number field wrong");

	// category field passes through unchanged
	cat_field_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		##1 left_category_out == $past(left_mid_ff[7:0]))
		else $error("category field wrong");

	// reserved word length codes give zero
	wlen_rsvd_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		left_word[POS_WLEN_HI:POS_WLEN_LO] == 3'h3
		|| left_word[POS_WLEN_HI:POS_WLEN_LO] == 3'h7
		|=> left_word_len_out == 5'h00)
		else $error("reserved word length not zero");

	// index steps by one between block starts
	index_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && !block_start_in && bit_index_out != LAST_FRAME
		|=> bit_index_out == $past(bit_index_out) + 8'h01)
		else $error("frame index did not step");

	// index wraps to zero after the last frame
	index_wrap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && bit_index_out == LAST_FRAME |=> bit_index_out == 8'h00)
		else $error("frame index did not wrap");

	// index and left status bit stand between frame ticks
	frame_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!frame_tick_in |=> $stable(bit_index_out) && $stable(left_status_bit_out))
		else $error("status output changed without a tick");

	// main scenarios
	block_start_c: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && block_start_in);
	copy_on_c: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && copy_left_to_right_in && left_status_bit_out);
	max24_c: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		left_max24_out && left_word_len_out == 5'h18);
	block_wrap_c: cover property (@(posedge ref_clk_in) disable iff (rst_in)
		frame_tick_in && bit_index_out == LAST_FRAME && !block_start_in);
endmodule // stcs_regs

// File: testbench/stcs_rx_model.sv
/* stcs_rx_model: receiver model that paces frames and gathers status words.
   Assumes status bits and index settle one cycle after each tick. */
`timescale 1ns/1ps
module stcs_rx_model (
	input wire logic clk_in,
	input wire logic [7:0] idx_in,
	input wire logic l_bit_in,
	input wire logic r_bit_in,
	output logic tick_out,
	output logic start_out
);
	logic [39:0] l_word;
	logic [39:0] r_word;
	int stray = 0;
	int idx_bad = 0;
	// idle frame port at time zero
	initial begin
		tick_out = 1'b0;
		start_out = 1'b0;
	end
	// one block; start held high between ticks, where it must be ignored
	task automatic run_block(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_in);
			tick_out = 1'b1;
			start_out = (i == 0);
			@(negedge clk_in);
			tick_out = 1'b0;
			start_out = 1'b1;
			if (idx_in !== i[7:0]) idx_bad++;
			if (i < 40) begin
				l_word[i] = l_bit_in;
				r_word[i] = r_bit_in;
			end else if ({l_bit_in, r_bit_in} !== 2'b00) stray++;
		end
	endtask
endmodule // stcs_rx_model

// File: testbench/tb_top.sv
/* tb_top: self-checking bench for the channel-status register bank.
   Assumes the receiver model paces frames; bench drives the register port. */
`timescale 1ns/1ps
module tb_top;
	import stcs_pkg::*;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [6:0] addr = 7'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic copy = 1'b0;
	logic tick, bstart, lbit, rbit, rvalid, lmax, lrk, lpcm, rpcm;
	logic [15:0] rdata;
	logic [7:0] idx, lcat;
	logic [4:0] lwl;
	logic [1:0] lacc;
	logic [3:0] lchan, lsrc;
	logic [4:0] wl_tab [8] = '{5'h00, 5'h10, 5'h12, 5'h00, 5'h13, 5'h14, 5'h11, 5'h00};
	int failures = 0;
	int checks_done = 0;
	stcs_regs DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .copy_left_to_right_in(copy), .frame_tick_in(tick),
		.block_start_in(bstart), .left_status_bit_out(lbit), .right_status_bit_out(rbit),
		.bit_index_out(idx), .left_word_len_out(lwl), .left_max24_out(lmax),
		.left_clk_acc_out(lacc), .left_rate_known_out(lrk), .left_chan_num_out(lchan),
		.left_source_out(lsrc), .left_category_out(lcat), .left_linear_pcm_out(lpcm),
		.right_linear_pcm_out(rpcm));
	stcs_rx_model PTN (.clk_in(ref_clk_in), .idx_in(idx), .l_bit_in(lbit),
		.r_bit_in(rbit), .tick_out(tick), .start_out(bstart));
	// free-running clock
	initial begin
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// watchdog, well past the few hundred cycles the tests take
	initial begin
		#200000;
		failures++;
		close_out();
	end
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
		@(negedge ref_clk_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge ref_clk_in);
		wr = 1'b0;
	endtask
	task automatic rd_chk(input string nm, input logic [6:0] a, input logic [15:0] exp);
		@(negedge ref_clk_in);
		addr = a;
		rd = 1'b1;
		@(negedge ref_clk_in);
		rd = 1'b0;
		chk(nm, {23'h0, 1'b1, exp}, {23'h0, rvalid, rdata});
	endtask
	task automatic wr_word(input logic [6:0] b, input logic [39:0] w);
		wr_reg(b, w[39:24]);
		wr_reg(b + 7'h01, w[23:8]);
		wr_reg(b + 7'h02, {8'h00, w[7:0]});
	endtask
	task automatic t_reset();
		for (int k = 0; k < 6; k++) rd_chk("reset reg", ADDR_LEFT_HIGH + k[6:0], 16'h0000);
		chk("reset decode", {5'h00, 8'hBF, 5'h00, 1'b0, 2'h0, 1'b1, 16'h0000, 2'h3},
			{5'h00, idx, lwl, lmax, lacc, lrk, lchan, lsrc, lcat, lpcm, rpcm});
		$display("test reset done");
	endtask
	task automatic t_regs();
		logic [15:0] d;
		for (int k = 0; k < 6; k++) wr_reg(ADDR_LEFT_HIGH + k[6:0], k[15:0] * 16'h1234 + 16'h8421);
		wr_reg(7'h50, 16'hFFFF);
		wr_reg(7'h57, 16'hFFFF);
		for (int k = 0; k < 6; k++) begin
			d = k[15:0] * 16'h1234 + 16'h8421;
			if (k == 2 || k == 5) d = d & 16'h00FF;
			rd_chk("reg readback", ADDR_LEFT_HIGH + k[6:0], d);
		end
		rd_chk("unmapped low", 7'h50, 16'h0000);
		rd_chk("unmapped high", 7'h57, 16'h0000);
		$display("test regs done");
	endtask
	// write then read back to back, then both in one cycle
	task automatic t_order();
		@(negedge ref_clk_in);
		addr = ADDR_RIGHT_MID;
		wdata = 16'h5AA5;
		wr = 1'b1;
		@(negedge ref_clk_in);
		wr = 1'b0;
		rd = 1'b1;
		@(negedge ref_clk_in);
		chk("wr then rd", {23'h0, 1'b1, 16'h5AA5}, {23'h0, rvalid, rdata});
		wdata = 16'h0FF0;
		wr = 1'b1;
		@(negedge ref_clk_in);
		wr = 1'b0;
		rd = 1'b0;
		chk("rd with wr", {23'h0, 1'b1, 16'h5AA5}, {23'h0, rvalid, rdata});
		rd_chk("wr landed", ADDR_RIGHT_MID, 16'h0FF0);
		$display("test order done");
	endtask
	task automatic t_fields();
		logic [4:0] e;
		for (int m = 0; m < 2; m++) begin
			for (int c = 0; c < 8; c++) begin
				wr_reg(ADDR_LEFT_HIGH, {4'hF, c[2:0], m[0], 2'h3, c[1:0], 1'b0, c[2:0]});
				@(negedge ref_clk_in);
				e = (wl_tab[c] == 5'd0) ? 5'd0 : wl_tab[c] + {m[0], 2'b00};
				chk("high decode", {31'h0, e, m[0], c[1:0], c < 3},
					{31'h0, lwl, lmax, lacc, lrk});
			end
		end
		wr_reg(ADDR_LEFT_MID, 16'h2A5C);
		wr_reg(ADDR_LEFT_LOW, 16'hFF02);
		@(negedge ref_clk_in);
		chk("mid decode", {23'h0, 16'h2A5C, 1'b0}, {23'h0, lchan, lsrc, lcat, lpcm});
		$display("test fields done");
	endtask
	task automatic t_serial();
		wr_word(ADDR_LEFT_HIGH, 40'h12_3456_789A);
		wr_word(ADDR_RIGHT_HIGH, 40'hC3_A50F_1E6D);
		PTN.run_block(192);
		chk("left word", 40'h12_3456_789A, PTN.l_word);
		chk("right word", 40'hC3_A50F_1E6D, PTN.r_word);
		chk("right pcm", 40'h1, {39'h0, rpcm});
		copy = 1'b1;
		PTN.run_block(40);
		chk("copied word", 40'h12_3456_789A, PTN.r_word);
		chk("copied pcm", 40'h0, {39'h0, rpcm});
		rd_chk("right kept", ADDR_RIGHT_HIGH, 16'hC3A5);
		chk("frame order", 40'h0, {PTN.stray[19:0], PTN.idx_bad[19:0]});
		$display("test serial done");
	endtask
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// reset for five cycles, then the tests in turn
	initial begin
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rst_in = 1'b0;
		t_reset();
		t_regs();
		t_order();
		t_fields();
		t_serial();
		close_out();
	end
endmodule // tb_top
